//--- common/cpm_pkg.sv
/*
 Shared constants for the collision, page and mode register slice.
 Assumes a host register port with 6-bit addresses and 8-bit data.
*/
package cpm_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] CPM_COLL_ADDR = 6'h0E;
    localparam logic [5:0] CPM_PAGE_ADDR = 6'h10;
    localparam logic [5:0] CPM_MODE_ADDR = 6'h11;
    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CPM_KEEP_BIT = 7;
    localparam int CPM_INVALID_BIT = 5;
    localparam int CPM_OVERRIDE_BIT = 7;
    localparam int CPM_DET_OFF_BIT = 2;
    localparam int CPM_RX_WAIT_BIT = 4;
    localparam logic [7:0] CPM_MODE_RESET = 8'h3B;
    localparam logic [7:0] CPM_PAGE_RESET = 8'h00;
    localparam logic CPM_KEEP_RESET = 1'h1;
    localparam logic CPM_INVALID_RESET = 1'h1;
    localparam logic [4:0] CPM_POS_RESET = 5'h00;
    // ------------------------------------------------------------
    // collision position range
    // ------------------------------------------------------------
    localparam logic [5:0] CPM_POS_MAX = 6'h20; // 32nd data bit
    localparam logic [5:0] CPM_POS_ONE = 6'h01;
    localparam logic [5:0] CPM_POS_ZERO = 6'h00;
endpackage

//--- rtl/cpm_collision_track.sv
/*
 Tracks the first collision of one received frame.
 Assumes data-bit strobes from the receive decoder on the same clock.
*/
`timescale 1ns/100ps
module cpm_collision_track
    import cpm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rx_frame_start,
    input wire logic rx_bit_valid,
    input wire logic rx_bit_collision,
    input wire logic rx_frame_end,
    output logic [4:0] first_collision_position,
    output logic collision_position_invalid
);
    // ------------------------------------------------------------
    // frame counters
    // ------------------------------------------------------------
    logic [5:0] bit_count_reg;
    logic [5:0] hit_pos_reg;
    logic hit_seen_reg;
    logic [5:0] cur_pos;

    assign cur_pos = bit_count_reg + CPM_POS_ONE;

    // data-bit count and first hit, restarted each frame
    always_ff @(posedge clk) begin
        if (!rst_b || rx_frame_start) begin
            bit_count_reg <= CPM_POS_ZERO;
            hit_seen_reg <= 1'b0;
            hit_pos_reg <= CPM_POS_ZERO;
        end else if (rx_bit_valid) begin
            // saturate so a long frame cannot wrap into range again
            if (bit_count_reg <= CPM_POS_MAX) begin
                bit_count_reg <= cur_pos;
            end
            if (rx_bit_collision && !hit_seen_reg) begin
                hit_seen_reg <= 1'b1; // RULE_04
                hit_pos_reg <= cur_pos;
            end
        end
    end

    // result published only at frame end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            first_collision_position <= CPM_POS_RESET;
            collision_position_invalid <= CPM_INVALID_RESET; // RULE_07
        end else if (rx_frame_end) begin // RULE_14
            first_collision_position <= hit_pos_reg[4:0]; // RULE_05
            collision_position_invalid <= !hit_seen_reg || (hit_pos_reg > CPM_POS_MAX); // RULE_03
        end
    end
endmodule

//--- rtl/cpm_regs.sv
/*
 Collision, page and mode registers with their side effects.
 Assumes the host interface supplies a latched 6-bit address and
 single-cycle read and write strobes on clk.
*/
`timescale 1ns/100ps
// Operation
// RULE_01: keep bit clear zeroes bits after collision
// RULE_02: host clears keep bit only at 106k
// RULE_03: invalid flag when none or out of range
// RULE_04: bits 4..0 give first data-bit collision
// RULE_05: 01h first bit, 00h thirty-second bit
// RULE_06: host trusts position only when flag clear
// RULE_07: collision register resets to 101XXXXXb
// RULE_08: override uses page field as A5 A4
// RULE_09: no override uses whole latched address
// RULE_10: page field ignored without override
// RULE_11: mode register resets 3Bh, fully writable
// RULE_12: detector disable stops mode detector
// RULE_13: receive wait waits for external field
// RULE_14: collision result updated at frame end
module cpm_regs
    import cpm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [5:0] addr_latch,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic [5:0] reg_addr,
    input wire logic rx_frame_start,
    input wire logic rx_bit_valid,
    input wire logic rx_bit_collision,
    input wire logic rx_bit_in,
    input wire logic rx_frame_end,
    output logic rx_bit_out,
    input wire logic autocoll_active,
    output logic mode_detector_run,
    input wire logic ext_field_seen,
    input wire logic rx_wait_request,
    output logic rx_wait_start,
    output logic [7:0] mode_bits
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic keep_bits_after_collision_reg;
    logic page_override_enable_reg;
    logic [1:0] register_page_reg;
    logic [7:0] general_mode_settings_reg;
    logic [4:0] first_collision_position;
    logic collision_position_invalid;
    logic coll_hit_reg;

    // ------------------------------------------------------------
    // address forming
    // ------------------------------------------------------------
    // upper bits swapped for the page only while override is set
    always_comb begin
        if (page_override_enable_reg) begin
            reg_addr = {register_page_reg, addr_latch[3:0]}; // RULE_08 RULE_10
        end else begin
            reg_addr = addr_latch; // RULE_09
        end
    end

    // ------------------------------------------------------------
    // host writes
    // ------------------------------------------------------------
    // reserved bits are not stored so they always read zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            keep_bits_after_collision_reg <= CPM_KEEP_RESET; // RULE_07
            page_override_enable_reg <= CPM_PAGE_RESET[CPM_OVERRIDE_BIT];
            register_page_reg <= CPM_PAGE_RESET[1:0];
            general_mode_settings_reg <= CPM_MODE_RESET; // RULE_11
        end else if (host_wr) begin
            if (reg_addr == CPM_COLL_ADDR) begin
                keep_bits_after_collision_reg <= host_wdata[CPM_KEEP_BIT];
            end else if (reg_addr == CPM_PAGE_ADDR) begin
                page_override_enable_reg <= host_wdata[CPM_OVERRIDE_BIT];
                register_page_reg <= host_wdata[1:0];
            end else if (reg_addr == CPM_MODE_ADDR) begin
                general_mode_settings_reg <= host_wdata; // RULE_11
            end
        end
    end

    // ------------------------------------------------------------
    // host reads
    // ------------------------------------------------------------
    // registered data, unmapped addresses read zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            host_rdata <= 8'h00;
        end else if (host_rd) begin
            if (reg_addr == CPM_COLL_ADDR) begin
                host_rdata <= {keep_bits_after_collision_reg, 1'b0,
                               collision_position_invalid, first_collision_position};
            end else if (reg_addr == CPM_PAGE_ADDR) begin
                host_rdata <= {page_override_enable_reg, 5'h00, register_page_reg};
            end else if (reg_addr == CPM_MODE_ADDR) begin
                host_rdata <= general_mode_settings_reg;
            end else begin
                host_rdata <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // collision tracking
    // ------------------------------------------------------------
    cpm_collision_track u_track (
        .clk(clk),
        .rst_b(rst_b),
        .rx_frame_start(rx_frame_start),
        .rx_bit_valid(rx_bit_valid),
        .rx_bit_collision(rx_bit_collision),
        .rx_frame_end(rx_frame_end),
        .first_collision_position(first_collision_position),
        .collision_position_invalid(collision_position_invalid)
    );

    // sticky within a frame so later bits are cleared too
    always_ff @(posedge clk) begin
        if (!rst_b || rx_frame_start) begin
            coll_hit_reg <= 1'b0;
        end else if (rx_bit_valid && rx_bit_collision) begin
            coll_hit_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // received bit masking
    // ------------------------------------------------------------
    // registered to keep data outputs glitch free
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_bit_out <= 1'b0;
        end else if (rx_bit_valid) begin
            rx_bit_out <= rx_bit_in && (keep_bits_after_collision_reg || !coll_hit_reg); // RULE_01
        end
    end

    // ------------------------------------------------------------
    // mode controls
    // ------------------------------------------------------------
    // detector runs only inside collision resolution
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode_detector_run <= 1'b0;
        end else begin
            mode_detector_run <= autocoll_active
                && !general_mode_settings_reg[CPM_DET_OFF_BIT]; // RULE_12
        end
    end

    // receive wait start held back until a field is seen while the receive wait bit (mode bit 4) is set
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_wait_start <= 1'b0;
        end else begin
            rx_wait_start <= rx_wait_request
                && (!general_mode_settings_reg[CPM_RX_WAIT_BIT] || ext_field_seen); // RULE_13
        end
    end

    assign mode_bits = general_mode_settings_reg;
endmodule

//--- sim/cpm_regs_assertions.sv
/* port checker for cpm_regs.
 bound from the testbench top file; sees top-level ports only */
`timescale 1ns/100ps
module cpm_regs_chk
    import cpm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire logic [5:0] reg_addr,
    input wire logic autocoll_active,
    input wire logic mode_detector_run,
    input wire logic ext_field_seen,
    input wire logic rx_wait_request,
    input wire logic rx_wait_start,
    input wire logic [7:0] mode_bits
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // a lone read of one address; writes in the same cycle are excluded
    sequence s_rd(a);
        host_rd && !host_wr && reg_addr == a;
    endsequence
    property p_mode_rd; s_rd(CPM_MODE_ADDR) |=> host_rdata == $past(mode_bits); endproperty
    property p_mode_wr; host_wr && reg_addr == CPM_MODE_ADDR |=> mode_bits == $past(host_wdata);
    endproperty
    property p_mode_rst; $rose(rst_b) |-> mode_bits == CPM_MODE_RESET; endproperty
    property p_coll_rsv; s_rd(CPM_COLL_ADDR) |=> !host_rdata[6]; endproperty
    property p_page_rsv; s_rd(CPM_PAGE_ADDR) |=> host_rdata[6:2] == 5'h00; endproperty
    property p_unmap; s_rd(6'h3F) |=> host_rdata == 8'h00; endproperty
    // guarded by the past reset so the release edge is not judged
    property p_det; $past(rst_b) |-> mode_detector_run ==
        $past(autocoll_active && !mode_bits[CPM_DET_OFF_BIT]); endproperty
    property p_rxw; $past(rst_b) |-> rx_wait_start ==
        $past(rx_wait_request && (!mode_bits[CPM_RX_WAIT_BIT] || ext_field_seen)); endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("mode read mismatch");
    a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");
    a_mode_rst: assert property (p_mode_rst) else $error("mode reset value");
    a_coll_rsv: assert property (p_coll_rsv) else $error("collision bit 6 set");
    a_page_rsv: assert property (p_page_rsv) else $error("page reserved set");
    a_unmap: assert property (p_unmap) else $error("unmapped read nonzero");
    a_det: assert property (p_det) else $error("mode detector run");
    a_rxw: assert property (p_rxw) else $error("receive wait start");
endmodule

//--- sim/cpm_host_model.sv
/* host side model: byte reads and writes on the register port.
 assumes the bench clock; drives on falling edges only */
`timescale 1ns/100ps
module cpm_host_model (
    input wire logic clk,
    input wire logic [7:0] host_rdata,
    output logic [5:0] addr_latch,
    output logic host_wr,
    output logic host_rd,
    output logic [7:0] host_wdata
);
    // idle values; data is inverted after a write so stale bytes never match
    initial begin
        addr_latch = 6'h00;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'h00;
    end
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        addr_latch = a;
        host_wdata = d;
        host_wr = 1'b1;
        @(negedge clk);
        host_wr = 1'b0;
        host_wdata = ~d;
    endtask
    task rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge clk);
        addr_latch = a;
        host_rd = 1'b1;
        @(negedge clk);
        host_rd = 1'b0;
        d = host_rdata;
    endtask
endmodule

//--- sim/tb_cpm_regs.sv
/* testbench for cpm_regs: register access, page override, frames.
 assumes cpm_host_model and the bound checker are compiled */
`timescale 1ns/100ps
module tb_cpm_regs;
    logic clk, rst_b, rx_frame_start, rx_bit_valid, rx_bit_collision, rx_bit_in, rx_frame_end;
    logic autocoll_active, ext_field_seen, rx_wait_request, host_wr, host_rd;
    logic rx_bit_out, mode_detector_run, rx_wait_start;
    logic [7:0] host_rdata, host_wdata, mode_bits, d, e, m;
    logic [5:0] addr_latch, reg_addr;
    int num_errors, n_compared, j;
    int cs[6] = '{1, 2, 8, 32, 0, 33};
    cpm_host_model H (.clk(clk), .host_rdata(host_rdata), .addr_latch(addr_latch),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata));
    cpm_regs DUT (.clk(clk), .rst_b(rst_b), .addr_latch(addr_latch), .host_wr(host_wr),
        .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
        .reg_addr(reg_addr), .rx_frame_start(rx_frame_start), .rx_bit_valid(rx_bit_valid),
        .rx_bit_collision(rx_bit_collision), .rx_bit_in(rx_bit_in),
        .rx_frame_end(rx_frame_end), .rx_bit_out(rx_bit_out),
        .autocoll_active(autocoll_active), .mode_detector_run(mode_detector_run),
        .ext_field_seen(ext_field_seen), .rx_wait_request(rx_wait_request),
        .rx_wait_start(rx_wait_start), .mode_bits(mode_bits));
    task chk(input string n, input logic [7:0] x, input logic [7:0] g);
        n_compared++;
        if (g !== x) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask
    task final_report;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // one frame of 34 bits; collision on bit c, none when c is 0
    task frame(input int c, input logic k);
        @(negedge clk) rx_frame_start = 1'b1;
        @(negedge clk) rx_frame_start = 1'b0;
        for (int i = 1; i <= 34; i++) begin
            rx_bit_valid = 1'b1;
            rx_bit_collision = (i == c);
            rx_bit_in = i[0];
            @(negedge clk);
            chk("bit_out", {7'h00, i[0] & !(!k && c != 0 && i > c)}, {7'h00, rx_bit_out});
        end
        rx_bit_valid = 1'b0;
        rx_frame_end = 1'b1;
        @(negedge clk) rx_frame_end = 1'b0;
        @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // watchdog: a hang counts as a mismatch
    initial begin
        #100000;
        num_errors++;
        final_report();
    end
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        {rst_b, rx_frame_start, rx_bit_valid, rx_bit_collision, rx_bit_in} = 5'h00;
        {rx_frame_end, autocoll_active, ext_field_seen, rx_wait_request} = 4'h0;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        H.rd(6'h0E, d);
        chk("coll_rst", 8'hA0, d & 8'hE0);
        H.rd(6'h10, d);
        chk("page_rst", 8'h00, d);
        H.rd(6'h11, d);
        chk("mode_rst", 8'h3B, d);
        H.wr(6'h11, 8'hC4);
        H.rd(6'h11, d);
        chk("mode_rw", 8'hC4, d);
        H.rd(6'h3F, d);
        chk("unmapped", 8'h00, d);
        H.wr(6'h10, 8'hFD);
        H.rd(6'h10, d);
        chk("page_rw", 8'h81, d);
        H.rd(6'h01, d);
        chk("ovr_addr", 8'h11, {2'h0, reg_addr});
        chk("ovr_data", 8'hC4, d);
        H.wr(6'h00, 8'h03);
        H.rd(6'h11, d);
        chk("latch_addr", 8'h11, {2'h0, reg_addr});
        chk("latch_data", 8'hC4, d);
        // keep bit cleared only for the bitwise anticollision case
        for (j = 0; j < 6; j++) begin
            H.wr(6'h0E, {cs[j] != 2, 7'h00});
            frame(cs[j], cs[j] != 2);
            H.rd(6'h0E, d);
            e = {cs[j] != 2, 1'b0, cs[j] == 0 || cs[j] > 32, cs[j][4:0]};
            m = e[5] ? 8'hE0 : 8'hFF;
            chk("coll", e & m, d & m);
        end
        autocoll_active = 1'b1;
        rx_wait_request = 1'b1;
        H.wr(6'h11, 8'h14);
        @(negedge clk);
        chk("det_off", 8'h00, {6'h00, mode_detector_run, rx_wait_start});
        ext_field_seen = 1'b1;
        @(negedge clk);
        chk("wait_field", 8'h01, {6'h00, mode_detector_run, rx_wait_start});
        H.wr(6'h11, 8'h00);
        @(negedge clk);
        chk("det_on", 8'h03, {6'h00, mode_detector_run, rx_wait_start});
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        H.rd(6'h11, d);
        chk("mode_rst2", 8'h3B, d);
        final_report();
    end
endmodule
bind cpm_regs cpm_regs_chk CHK (.clk(clk), .rst_b(rst_b), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata), .reg_addr(reg_addr),
    .autocoll_active(autocoll_active), .mode_detector_run(mode_detector_run),
    .ext_field_seen(ext_field_seen), .rx_wait_request(rx_wait_request),
    .rx_wait_start(rx_wait_start), .mode_bits(mode_bits));
